// ===== shared/usb_pwr_pkg.sv
/*
 Package for the link power and endpoint interrupt block: register byte
 addresses, field positions, reset values, endpoint count and carrier types.
 Assumes a 32-bit APB register bus with word-aligned registers.
*/
package usb_pwr_pkg;

	// ==========================================
	// Register byte addresses
	localparam logic [7:0] ADDR_POWER_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TX_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_RX_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_TX_ENABLES = 8'h0c;
	localparam logic [7:0] ADDR_DEV_CTRL = 8'h10;
	localparam logic [7:0] ADDR_COMMON_IRQ = 8'h14;
	localparam logic [7:0] ADDR_COMMON_MASK = 8'h18;

	// ==========================================
	// Power control field positions
	localparam int PB_ISO_DEFER = 7;
	localparam int PB_SOFT_ATTACH = 6;
	localparam int PB_HS_ALLOW = 5;
	localparam int PB_HS_ACTIVE = 4;
	localparam int PB_BUS_RESET = 3;
	localparam int PB_RESUME = 2;
	localparam int PB_SUSPEND = 1;
	localparam int PB_SUSP_OUT_EN = 0;
	localparam logic [7:0] POWER_RESET = 8'h20;

	// Device control field: mode bit (0 peripheral, 1 host)
	localparam int DC_HOST_MODE = 2;

	// Common interrupt field positions
	localparam int CI_SOF = 3;
	localparam int CI_RESET = 2;
	localparam int CI_RESUME = 1;
	localparam int CI_SUSPEND = 0;
	localparam logic [7:0] COMMON_MASK_RESET = 8'h06;

	// Endpoint flag layout
	localparam logic [4:0] TX_FLAG_MASK = 5'h1f;
	localparam logic [4:0] RX_FLAG_MASK = 5'h1e;
	localparam int N_EP = 4;

	// ==========================================
	// Line signalling from the transceiver side
	typedef struct packed {
		logic bus_reset;
		logic resume_seen;
		logic suspend_seen;
		logic sof;
		logic in_token;
		logic hs_done;
	} line_events_t;

	// Per-endpoint transmit state
	typedef struct packed {
		logic [N_EP:0] tx_pkt_ready;
		logic [N_EP:0] tx_iso;
	} ep_state_t;

	typedef enum logic [1:0] {ISO_IDLE, ISO_WAIT_SOF, ISO_ARMED} iso_state_t;

endpackage : usb_pwr_pkg

// ===== rtl/usb_pwr_irq.sv
/*
 Link power control and endpoint interrupt flags of a dual-role USB
 controller, as an APB slave. Assumes the line events arrive synchronous
 to CLK as one-cycle pulses (levels for bus_reset).
*/
// Register access over APB and the register addresses were decided locally.
// What this block does
// R01 - Deferred iso packet waits for next SOF
// R02 - IN before SOF gets zero-length packet
// R03 - Deferral only peripheral mode, iso endpoints
// R04 - Soft attach enables or tri-states data lines in peripheral mode
// R05 - High-speed allow steers negotiation, resets one
// R06 - High-speed active set after negotiation
// R07 - Reset bit shows bus reset; host writable
// R08 - Drive resume while suspended and bit set
// R09 - Software clears resume after 10-15 ms
// R10 - Host mode sets resume on target resume
// R11 - Host software suspend bit enters suspend
// R12 - Peripheral suspend flag set, cleared by read/resume
// R13 - Suspend output only when its enable set
// R14 - Transmit flags read-only, bits 4:0
// R15 - Receive flags read-only, bits 4:1
// R16 - Transmit enables gate each endpoint
// R17 - Mode bit picks peripheral or host
// R18 - Common interrupt read clears the bits it returned
// R19 - Endpoint request when flag and enable set; rx flags here request with no enable
`timescale 1ns/100ps
module usb_pwr_irq
	import usb_pwr_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire usb_pwr_pkg::line_events_t LINE_EV,
	input wire usb_pwr_pkg::ep_state_t EP_STATE,
	input wire logic [4:0] TX_EP_EVENT,
	input wire logic [4:0] RX_EP_EVENT,
	output logic DATA_LINE_OE,
	output logic HS_NEGOTIATE,
	output logic RESUME_DRIVE,
	output logic BUS_SUSPEND,
	output logic SUSPEND_OUT,
	output logic ISO_SEND,
	output logic ISO_ZERO_LEN,
	output logic EP_IRQ,
	output logic USB_IRQ
);
	import usb_pwr_pkg::*;

	// ==========================================
	// Bus decode
	logic [7:0] power_q, power_d;
	logic [7:0] device_control_reg_q;
	logic [4:0] tx_flags_q, tx_flags_d;
	logic [4:0] rx_flags_q, rx_flags_d;
	logic [4:0] tx_en_q;
	logic [7:0] common_q, common_d;
	logic [7:0] cmask_q;
	logic [31:0] rdata_d;
	iso_state_t iso_q, iso_d;
	logic iso_send_d, iso_zero_d;

	// Side effects land only at the edge that completes the transfer
	wire access = PSEL && PENABLE && PREADY;
	wire wr = access && PWRITE;
	wire rd = access && !PWRITE;
	wire hit_pwr = PADDR == ADDR_POWER_CTRL;
	wire hit_tx = PADDR == ADDR_TX_FLAGS;
	wire hit_rx = PADDR == ADDR_RX_FLAGS;
	wire hit_txe = PADDR == ADDR_TX_ENABLES;
	wire hit_dc = PADDR == ADDR_DEV_CTRL;
	wire hit_ci = PADDR == ADDR_COMMON_IRQ;
	wire hit_cm = PADDR == ADDR_COMMON_MASK;
	wire mapped = hit_pwr | hit_tx | hit_rx | hit_txe | hit_dc | hit_ci | hit_cm;
	wire host = device_control_reg_q[DC_HOST_MODE]; // R17
	wire wr_pwr = wr && hit_pwr;

	// ==========================================
	// Power control next value
	always_comb
	begin
		power_d = power_q;
		if (wr_pwr)
		begin
			power_d[PB_ISO_DEFER] = PWDATA[PB_ISO_DEFER];
			power_d[PB_SOFT_ATTACH] = PWDATA[PB_SOFT_ATTACH];
			power_d[PB_HS_ALLOW] = PWDATA[PB_HS_ALLOW]; // R05
			power_d[PB_RESUME] = PWDATA[PB_RESUME]; // R08
			power_d[PB_SUSP_OUT_EN] = PWDATA[PB_SUSP_OUT_EN];
			if (host)
			begin
				power_d[PB_BUS_RESET] = PWDATA[PB_BUS_RESET]; // R07
				power_d[PB_SUSPEND] = PWDATA[PB_SUSPEND]; // R11
			end
		end
		// Peripheral: reset bit mirrors bus reset, read-only
		if (!host)
			power_d[PB_BUS_RESET] = LINE_EV.bus_reset; // R07
		// Negotiation result latched, cleared when a new bus reset starts
		if (LINE_EV.bus_reset && !power_q[PB_BUS_RESET])
			power_d[PB_HS_ACTIVE] = 1'b0;
		if (LINE_EV.hs_done && power_q[PB_HS_ALLOW])
			power_d[PB_HS_ACTIVE] = 1'b1; // R06
		// Peripheral suspend flag cleared by interrupt read or resume
		if (!host && ((rd && hit_ci) || power_d[PB_RESUME]))
			power_d[PB_SUSPEND] = 1'b0; // R12
		if (!host && LINE_EV.suspend_seen)
			power_d[PB_SUSPEND] = 1'b1; // R12
		// Host: target resume while suspended sets resume bit
		if (host && power_q[PB_SUSPEND] && LINE_EV.resume_seen)
			power_d[PB_RESUME] = 1'b1; // R10
	end

	// ==========================================
	// Endpoint interrupt-active flags, one slice per endpoint
	logic [N_EP:0] iso_pend;
	wire tx_rd_clr = rd && hit_tx;
	wire rx_rd_clr = rd && hit_rx;
	genvar gi;
	generate
		for (gi = 0; gi <= N_EP; gi++)
		begin : g_ep_flag
			// Flag survives unless its set value was just read out
			wire tx_keep = tx_flags_q[gi] && !(tx_rd_clr && PRDATA[gi]);
			wire rx_keep = rx_flags_q[gi] && !(rx_rd_clr && PRDATA[gi]);
			// Event wins over a clear in the same cycle
			assign tx_flags_d[gi] = TX_FLAG_MASK[gi] && (TX_EP_EVENT[gi] || tx_keep); // R14
			assign rx_flags_d[gi] = RX_FLAG_MASK[gi] && (RX_EP_EVENT[gi] || rx_keep); // R15
			// Iso endpoint with a packet waiting
			assign iso_pend[gi] = EP_STATE.tx_pkt_ready[gi] && EP_STATE.tx_iso[gi]; // R03
		end
	endgenerate

	// Common interrupt flags: read clears, events win
	always_comb
	begin
		// Clear exactly the bits handed out, so no event is lost
		common_d = (rd && hit_ci) ? (common_q & ~PRDATA[7:0]) : common_q; // R18
		common_d[CI_SOF] = common_d[CI_SOF] | LINE_EV.sof;
		common_d[CI_RESET] = common_d[CI_RESET] | (LINE_EV.bus_reset & ~power_q[PB_BUS_RESET]);
		common_d[CI_RESUME] = common_d[CI_RESUME] | (LINE_EV.resume_seen & power_q[PB_SUSPEND]);
		common_d[CI_SUSPEND] = common_d[CI_SUSPEND] | LINE_EV.suspend_seen;
	end

	// ==========================================
	// Isochronous deferral sequencer
	wire iso_ready = |iso_pend;
	wire iso_on = power_q[PB_ISO_DEFER] && !host; // R03
	always_comb
	begin
		iso_d = iso_q;
		iso_send_d = 1'b0;
		iso_zero_d = 1'b0;
		unique case (iso_q)
			ISO_IDLE:
			begin
				if (iso_on && iso_ready)
					iso_d = ISO_WAIT_SOF; // R01
			end
			ISO_WAIT_SOF:
			begin
				if (!iso_ready || !iso_on)
					iso_d = ISO_IDLE;
				else if (LINE_EV.sof)
					iso_d = ISO_ARMED; // R01
				else if (LINE_EV.in_token)
					iso_zero_d = 1'b1; // R02
			end
			ISO_ARMED:
			begin
				if (!iso_ready)
					iso_d = ISO_IDLE;
				else if (LINE_EV.in_token)
				begin
					iso_send_d = 1'b1; // R01
					iso_d = ISO_IDLE;
				end
			end
			// Unused code falls back to idle
			default:
				iso_d = ISO_IDLE;
		endcase
	end

	// Read mux, reserved bits zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (hit_pwr)
			rdata_d[7:0] = power_q;
		if (hit_tx)
			rdata_d[4:0] = tx_flags_q; // R14
		if (hit_rx)
			rdata_d[4:0] = rx_flags_q; // R15
		if (hit_txe)
			rdata_d[4:0] = tx_en_q;
		if (hit_dc)
			rdata_d[7:0] = device_control_reg_q;
		if (hit_ci)
			rdata_d[7:0] = common_q;
		if (hit_cm)
			rdata_d[7:0] = cmask_q;
	end

	// ==========================================
	// Power and device control registers
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			power_q <= POWER_RESET; // R05
			device_control_reg_q <= 8'h00;
		end
		else
		begin
			power_q <= power_d;
			if (wr && hit_dc)
				device_control_reg_q <= PWDATA[7:0]; // R17
		end
	end

	// Endpoint flags and transmit enables
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			tx_flags_q <= 5'h00;
			rx_flags_q <= 5'h00;
			tx_en_q <= 5'h00;
		end
		else
		begin
			tx_flags_q <= tx_flags_d;
			rx_flags_q <= rx_flags_d;
			if (wr && hit_txe)
				tx_en_q <= PWDATA[4:0]; // R16
		end
	end

	// Common interrupt flags and their mask
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			common_q <= 8'h00;
			cmask_q <= COMMON_MASK_RESET;
		end
		else
		begin
			common_q <= common_d;
			if (wr && hit_cm)
				cmask_q <= PWDATA[7:0];
		end
	end

	// Isochronous sequencer state
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			iso_q <= ISO_IDLE;
		else
			iso_q <= iso_d;
	end

	// ==========================================
	// Output next values
	// One wait state: answer in the second access cycle
	wire ready_d = PSEL && PENABLE && !PREADY;
	wire slverr_d = ready_d && !mapped;
	wire line_oe_d = !host && power_d[PB_SOFT_ATTACH]; // R04
	wire negotiate_d = power_d[PB_HS_ALLOW] && LINE_EV.bus_reset; // R05
	wire resume_drive_d = power_d[PB_RESUME] && power_q[PB_SUSPEND]; // R08
	wire bus_suspend_d = host && power_d[PB_SUSPEND]; // R11
	wire suspend_out_d = power_d[PB_SUSP_OUT_EN] && power_d[PB_SUSPEND]; // R13
	// Rx flags carry no enable here, so any rx flag requests
	wire ep_irq_d = |((tx_flags_d & tx_en_q) | rx_flags_d); // R19
	wire usb_irq_d = |(common_d & cmask_q);

	// ==========================================
	// Bus answer outputs
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PRDATA <= rdata_d;
			PREADY <= ready_d;
			PSLVERR <= slverr_d;
		end
	end

	// Line control outputs
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			DATA_LINE_OE <= 1'b0;
			HS_NEGOTIATE <= 1'b0;
			RESUME_DRIVE <= 1'b0;
			BUS_SUSPEND <= 1'b0;
			SUSPEND_OUT <= 1'b0;
		end
		else
		begin
			DATA_LINE_OE <= line_oe_d; // R04
			HS_NEGOTIATE <= negotiate_d; // R05
			RESUME_DRIVE <= resume_drive_d; // R08
			BUS_SUSPEND <= bus_suspend_d; // R11
			SUSPEND_OUT <= suspend_out_d; // R13
		end
	end

	// Isochronous answer pulses
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			ISO_SEND <= 1'b0;
			ISO_ZERO_LEN <= 1'b0;
		end
		else
		begin
			ISO_SEND <= iso_send_d; // R01
			ISO_ZERO_LEN <= iso_zero_d; // R02
		end
	end

	// Interrupt request levels
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			EP_IRQ <= 1'b0;
			USB_IRQ <= 1'b0;
		end
		else
		begin
			EP_IRQ <= ep_irq_d; // R19
			USB_IRQ <= usb_irq_d;
		end
	end

endmodule : usb_pwr_irq

// ===== sim/usb_line_model.sv
/* Host side line model for usb_pwr_irq.
 Events are synchronous to CLK. */
`timescale 1ns/100ps
module usb_line_model
	import usb_pwr_pkg::*;
(
	input wire logic CLK,
	output usb_pwr_pkg::line_events_t LINE_EV
);
	initial LINE_EV = '0;
	// ==========
	// Raise one event for n cycles
	task automatic hold(input int b, input int n);
		@(posedge CLK);
		LINE_EV[b] <= 1'b1;
		repeat (n) @(posedge CLK);
		LINE_EV[b] <= 1'b0;
	endtask : hold
endmodule : usb_line_model

// ===== sim/usb_pwr_irq_properties.sv
/* Port checker for usb_pwr_irq.
 Bound to the block below. */
`timescale 1ns/100ps
module usb_pwr_irq_properties
	import usb_pwr_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire usb_pwr_pkg::line_events_t LINE_EV,
	input wire logic [4:0] RX_EP_EVENT,
	input wire logic HS_NEGOTIATE,
	input wire logic ISO_SEND,
	input wire logic ISO_ZERO_LEN,
	input wire logic EP_IRQ
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	// ==========
	// Read data and line answers
	wire logic rd = PREADY && !PWRITE;
	AST_TX: assert property (rd && PADDR == ADDR_TX_FLAGS |-> PRDATA[31:5] == '0)
		else $error("tx flags high");
	AST_RX: assert property (rd && PADDR == ADDR_RX_FLAGS |-> PRDATA[31:5] == '0 && !PRDATA[0])
		else $error("rx flags reserved");
	AST_ZLP: assert property (ISO_ZERO_LEN |-> $past(LINE_EV.in_token))
		else $error("zlp untimely");
	AST_SEND: assert property (ISO_SEND |-> $past(LINE_EV.in_token) && !ISO_ZERO_LEN)
		else $error("send untimely");
	AST_HS: assert property (HS_NEGOTIATE |-> $past(LINE_EV.bus_reset))
		else $error("negotiate untimely");
	AST_EP: assert property (RX_EP_EVENT[4:1] != '0 |=> EP_IRQ)
		else $error("no request");
	AST_ACK: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("no ready");
	AST_ERR: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == '0))
		else $error("bad error");
endmodule : usb_pwr_irq_properties
bind usb_pwr_irq usb_pwr_irq_properties usb_pwr_irq_properties_i (.CLK, .NRST, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .LINE_EV, .RX_EP_EVENT,
	.HS_NEGOTIATE, .ISO_SEND, .ISO_ZERO_LEN, .EP_IRQ);

// ===== sim/tb_usb_pwr_irq.sv
/* Bench for usb_pwr_irq.
 Line model plays the host. */
`timescale 1ns/100ps
module tb_usb_pwr_irq;
	import usb_pwr_pkg::*;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = '0;
	logic [31:0] PWDATA = '0;
	logic [31:0] PRDATA, rd, seed = 32'h00002cc1;
	logic PREADY, PSLVERR, err;
	line_events_t LINE_EV;
	ep_state_t EP_STATE = '0;
	logic [4:0] TX_EP_EVENT = '0;
	logic [4:0] RX_EP_EVENT = '0;
	logic [4:0] en, ev;
	logic DATA_LINE_OE, HS_NEGOTIATE, RESUME_DRIVE, BUS_SUSPEND;
	logic SUSPEND_OUT, ISO_SEND, ISO_ZERO_LEN, EP_IRQ, USB_IRQ;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	always #5 CLK = ~CLK;
	usb_pwr_irq usb_pwr_irq_i (.*);
	usb_line_model usb_line_model_i (.CLK, .LINE_EV);
	// ==========
	// Helpers
	function automatic void xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction : xs
	function automatic logic exp_req(input logic [4:0] f, input logic [4:0] e);
		return |(f & e);
	endfunction : exp_req
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge CLK);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(rd, exp);
	endtask : rdchk
	task automatic close_out();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	// Hang guard
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			mismatches++;
			close_out();
		end
	end
	// ==========
	// Main sequence
	initial
	begin
		repeat (20) @(posedge CLK);
		NRST <= 1'b1;
		rdchk(ADDR_POWER_CTRL, 32'h00000020);
		rdchk(ADDR_RX_FLAGS, '0);
		wr(ADDR_DEV_CTRL, '0);
		repeat (6)
		begin
			xs();
			en = seed[4:0];
			ev = seed[9:5];
			wr(ADDR_TX_ENABLES, {27'h0, en});
			TX_EP_EVENT <= ev;
			@(posedge CLK);
			TX_EP_EVENT <= '0;
			repeat (2) @(posedge CLK);
			chk(EP_IRQ, exp_req(ev, en));
			rdchk(ADDR_TX_ENABLES, {27'h0, en});
			rdchk(ADDR_TX_FLAGS, {27'h0, ev});
		end
		TX_EP_EVENT <= '0;
		RX_EP_EVENT <= 5'h1f;
		@(posedge CLK);
		RX_EP_EVENT <= '0;
		rdchk(ADDR_RX_FLAGS, 32'h0000001e);
		rdchk(ADDR_RX_FLAGS, '0);
		wr(ADDR_POWER_CTRL, 32'h00000040);
		chk(DATA_LINE_OE, 1'b1);
		EP_STATE <= 10'h042;
		wr(ADDR_POWER_CTRL, 32'h000000a0);
		chk(DATA_LINE_OE, 1'b0);
		usb_line_model_i.hold(1, 1);
		@(posedge CLK);
		chk(ISO_ZERO_LEN, 1'b1);
		usb_line_model_i.hold(2, 1);
		usb_line_model_i.hold(1, 1);
		@(posedge CLK);
		chk(ISO_SEND, 1'b1);
		fork
			usb_line_model_i.hold(5, 10);
		join_none
		repeat (4) @(posedge CLK);
		chk(HS_NEGOTIATE, 1'b1);
		rdchk(ADDR_POWER_CTRL, 32'h000000a8);
		repeat (4) @(posedge CLK);
		usb_line_model_i.hold(0, 1);
		rdchk(ADDR_POWER_CTRL, 32'h000000b0);
		wr(ADDR_POWER_CTRL, 32'h00000001);
		wr(ADDR_COMMON_MASK, 32'h00000001);
		chk(USB_IRQ, 1'b0);
		usb_line_model_i.hold(3, 1);
		repeat (2) @(posedge CLK);
		chk(SUSPEND_OUT, 1'b1);
		chk(USB_IRQ, 1'b1);
		rdchk(ADDR_COMMON_IRQ, 32'h0000000d);
		repeat (2) @(posedge CLK);
		chk(SUSPEND_OUT, 1'b0);
		chk(USB_IRQ, 1'b0);
		wr(ADDR_DEV_CTRL, 32'h00000004);
		wr(ADDR_POWER_CTRL, 32'h00000002);
		chk(BUS_SUSPEND, 1'b1);
		usb_line_model_i.hold(4, 1);
		repeat (2) @(posedge CLK);
		chk(RESUME_DRIVE, 1'b1);
		wr(ADDR_POWER_CTRL, 32'h00000002);
		chk(RESUME_DRIVE, 1'b0);
		wr(ADDR_POWER_CTRL, 32'h00000088);
		usb_line_model_i.hold(1, 1);
		@(posedge CLK);
		chk(ISO_ZERO_LEN, 1'b0);
		rdchk(ADDR_POWER_CTRL, 32'h00000098);
		rdchk(8'h40, '0);
		chk(err, 1'b1);
		close_out();
	end
endmodule : tb_usb_pwr_irq
